// File: include/adcpc_pkg.sv
// Shared constants and types for the converter control block
`default_nettype none
package adcpc_pkg;
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          POR_TIME_NS      = 10000;
    localparam int          POR_CYCLES       = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          POR_CW           = $clog2(POR_CYCLES + 1);
    localparam int          INT_CONV_TIME_NS = 3600;
    localparam int          RES_BITS         = 10;
    localparam int          CONV_TICKS       = 13;
    localparam int          ACQ_TICKS        = 3;
    localparam int          TICK_CW          = $clog2(CONV_TICKS + 1);
    localparam int          INT_TICK_RAW     = INT_CONV_TIME_NS / (CONV_TICKS * CLK_PERIOD_NS);
    localparam int          INT_TICK_CYCLES  = (INT_TICK_RAW < 1) ? 1 : INT_TICK_RAW;
    localparam int          DIV_CW           = 8;
    localparam int          BYTE_W           = 8;
    localparam int          ADDR_W           = 3;
    localparam int          CB_PD_HI         = 7;
    localparam int          CB_PD_LO         = 6;
    localparam int          CB_ACQ           = 5;
    localparam int          CB_SGL           = 4;
    localparam int          CB_UNI           = 3;
    localparam int          CB_ADDR_HI       = 2;
    localparam int          CB_ADDR_LO       = 0;
    localparam logic [1:0]  PD_FULL          = 2'h0;
    localparam logic [1:0]  PD_STANDBY       = 2'h1;
    localparam logic [1:0]  PD_INT_CLK       = 2'h2;
    localparam logic [1:0]  PD_EXT_CLK       = 2'h3;
    localparam logic [7:0]  CTRL_RESET       = 8'hc0;

    typedef enum {ST_POR, ST_IDLE, ST_ACQ, ST_CONV, ST_STANDBY, ST_SHUTDOWN} adcpc_state_type;
endpackage : adcpc_pkg
`default_nettype wire

// File: rtl/adcpc_pin_sync.sv
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`default_nettype none
module adcpc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinOut
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] out_reg;
    logic [WIDTH-1:0] out_next;

    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            out_next[i] = (stage2_reg[i] == stage3_reg[i]) ? stage3_reg[i] : out_reg[i];
        end
    end

    // Idle level of chip select and both strobes is high, so reset every stage to ones
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            stage1_reg <= '1;
            stage2_reg <= '1;
            stage3_reg <= '1;
            out_reg    <= '1;
        end
        else
        begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            out_reg    <= out_next;
        end
    end

    assign pinOut = out_reg;
endmodule : adcpc_pin_sync
`default_nettype wire

// File: rtl/adcpc_sar.sv
// Successive-approximation sequencer stepped by conversion clock ticks
`default_nettype none
module adcpc_sar
    import adcpc_pkg::*;
#(
    parameter int BITS  = RES_BITS,
    parameter int TICKS = CONV_TICKS
) (
    input  wire logic            core_clk,
    input  wire logic            rst_b,
    input  wire logic            start,
    input  wire logic            tick,
    input  wire logic            compHigh,
    output logic      [BITS-1:0] dacCode,
    output logic      [BITS-1:0] result,
    output logic                 done
);
    logic               busy_reg;
    logic               busy_next;
    logic [TICK_CW-1:0] cnt_reg;
    logic [TICK_CW-1:0] cnt_next;
    logic [BITS-1:0]    code_reg;
    logic [BITS-1:0]    code_next;
    logic [BITS-1:0]    result_reg;
    logic [BITS-1:0]    result_next;
    logic               done_reg;
    logic               done_next;

    always_comb
    begin
        int bitIdx;
        bitIdx      = BITS - 1 - int'(cnt_reg);
        busy_next   = busy_reg;
        cnt_next    = cnt_reg;
        code_next   = code_reg;
        result_next = result_reg;
        done_next   = 1'b0;
        if (start)
        begin
            busy_next = 1'b1;
            cnt_next  = '0;
            code_next = {1'b1, {(BITS-1){1'b0}}};
        end
        else if (busy_reg && tick)
        begin
            // Keep or drop the trial bit, then try the next lower one
            if (bitIdx >= 0)
            begin
                code_next[bitIdx] = compHigh;
            end
            if (bitIdx >= 1)
            begin
                code_next[bitIdx-1] = 1'b1;
            end
            cnt_next = cnt_reg + TICK_CW'(1);
            if (int'(cnt_reg) == TICKS - 1)
            begin
                busy_next   = 1'b0;
                done_next   = 1'b1;
                result_next = code_next;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            busy_reg   <= 1'b0;
            cnt_reg    <= '0;
            code_reg   <= '0;
            result_reg <= '0;
            done_reg   <= 1'b0;
        end
        else
        begin
            busy_reg   <= busy_next;
            cnt_reg    <= cnt_next;
            code_reg   <= code_next;
            result_reg <= result_next;
            done_reg   <= done_next;
        end
    end

    assign dacCode = code_reg;
    assign result  = result_reg;
    assign done    = done_reg;
endmodule : adcpc_sar
`default_nettype wire

// File: rtl/adcpc_port_control.sv
// Control, power-down and byte-wide output path of the converter
`default_nettype none
module adcpc_port_control
    import adcpc_pkg::*;
#(
    parameter bit EIGHT_CHANNEL = 1'b1
) (
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    input  wire logic                chipSelB,
    input  wire logic                writeB,
    input  wire logic                readB,
    input  wire logic                high_byte_select,
    input  wire logic                convClkPin,
    input  wire logic [BYTE_W-1:0]   dataIn,
    input  wire logic                compHigh,
    output logic      [BYTE_W-1:0]   dataOut,
    output logic                     dataOe,
    output logic                     convDoneB,
    output logic      [ADDR_W-1:0]   muxPosSel,
    output logic      [ADDR_W-1:0]   muxNegSel,
    output logic                     muxNegCom,
    output logic                     trackHold,
    output logic      [RES_BITS-1:0] dacCode,
    output logic                     analogPowerOn,
    output logic                     refPowerOn,
    output logic                     intClkMode,
    output logic                     porBusy
);
    localparam int SYNC_W = 5 + BYTE_W;

    logic [SYNC_W-1:0]   syncOut;
    logic                csS;
    logic                wrS;
    logic                rdS;
    logic                hbS;
    logic                clkS;
    logic [BYTE_W-1:0]   dataS;
    logic                selected;
    logic                wrRise;
    logic                rdFall;
    logic                clkRise;
    logic                readActive;
    logic                tick;
    logic                sarStart;
    logic                sarDone;
    logic [RES_BITS-1:0] sarResult;
    logic [1:0]          pdSel;

    adcpc_state_type     state_reg;
    adcpc_state_type     state_next;
    logic [POR_CW-1:0]   porCnt_reg;
    logic [POR_CW-1:0]   porCnt_next;
    logic [TICK_CW-1:0]  acqCnt_reg;
    logic [TICK_CW-1:0]  acqCnt_next;
    logic [DIV_CW-1:0]   divCnt_reg;
    logic [DIV_CW-1:0]   divCnt_next;
    logic [BYTE_W-1:0]   ctrl_reg;
    logic [BYTE_W-1:0]   ctrl_next;
    logic                intClk_reg;
    logic                intClk_next;
    logic [6:0]          mux_reg;
    logic [6:0]          mux_next;
    logic [RES_BITS-1:0] result_reg;
    logic [RES_BITS-1:0] result_next;
    logic                resultUni_reg;
    logic                resultUni_next;
    logic                convDoneB_reg;
    logic                convDoneB_next;
    logic [BYTE_W-1:0]   dataOut_reg;
    logic [BYTE_W-1:0]   dataOut_next;
    logic                wrPrev_reg;
    logic                rdPrev_reg;
    logic                clkPrev_reg;

    // Returns {positive select, negative select, negative is common}
    function automatic logic [6:0] muxDecode(input logic [ADDR_W-1:0] addr,
                                             input logic              single);
        logic [ADDR_W-1:0] a;
        a = addr;
        if (!EIGHT_CHANNEL)
        begin
            a[ADDR_W-1] = 1'b0;
        end
        if (single)
        begin
            muxDecode = {a, a, 1'b1};
        end
        else
        begin
            muxDecode = {a, a[ADDR_W-1:1], ~a[0], 1'b0};
        end
    endfunction : muxDecode

    // Offset binary from the SAR becomes two's complement in bipolar mode
    function automatic logic [RES_BITS-1:0] codeResult(input logic [RES_BITS-1:0] raw,
                                                       input logic                uni);
        codeResult = uni ? raw : {~raw[RES_BITS-1], raw[RES_BITS-2:0]};
    endfunction : codeResult

    function automatic logic [BYTE_W-1:0] highByte(input logic [RES_BITS-1:0] res,
                                                   input logic                uni);
        logic fill;
        fill     = uni ? 1'b0 : res[RES_BITS-1];
        highByte = {{(2*BYTE_W-RES_BITS){fill}}, res[RES_BITS-1:BYTE_W]};
    endfunction : highByte

    adcpc_pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .pinIn    ({chipSelB, writeB, readB, high_byte_select, convClkPin, dataIn}),
        .pinOut   (syncOut)
    );

    assign {csS, wrS, rdS, hbS, clkS, dataS} = syncOut;

    // Deselected chip sees no strobe and no conversion clock edge
    assign selected   = !csS;
    assign wrRise     = selected && wrS && !wrPrev_reg;
    assign readActive = selected && !rdS;
    assign rdFall     = readActive && rdPrev_reg;
    assign clkRise    = selected && clkS && !clkPrev_reg;
    assign tick       = intClk_reg ? (divCnt_reg == DIV_CW'(INT_TICK_CYCLES - 1)) : clkRise;
    assign pdSel      = ctrl_reg[CB_PD_HI:CB_PD_LO];

    adcpc_sar u_sar (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .start    (sarStart),
        .tick     (tick),
        .compHigh (compHigh),
        .dacCode  (dacCode),
        .result   (sarResult),
        .done     (sarDone)
    );

    always_comb
    begin
        state_next     = state_reg;
        porCnt_next    = porCnt_reg;
        acqCnt_next    = acqCnt_reg;
        ctrl_next      = ctrl_reg;
        intClk_next    = intClk_reg;
        mux_next       = mux_reg;
        result_next    = result_reg;
        resultUni_next = resultUni_reg;
        sarStart       = 1'b0;
        divCnt_next    = '0;
        if (intClk_reg && !tick)
        begin
            divCnt_next = divCnt_reg + DIV_CW'(1);
        end
        case (state_reg)
            ST_POR:
            begin
                if (porCnt_reg == POR_CW'(POR_CYCLES - 1))
                begin
                    state_next = ST_IDLE;
                end
                else
                begin
                    porCnt_next = porCnt_reg + POR_CW'(1);
                end
            end
            ST_IDLE, ST_STANDBY, ST_SHUTDOWN:
            begin
                // A write also ends either power-down mode
                if (wrRise)
                begin
                    state_next  = ST_ACQ;
                    acqCnt_next = '0;
                    ctrl_next   = dataS;
                    mux_next    = muxDecode(dataS[CB_ADDR_HI:CB_ADDR_LO], dataS[CB_SGL]);
                    if (dataS[CB_PD_HI])
                    begin
                        intClk_next = !dataS[CB_PD_LO];
                    end
                end
            end
            ST_ACQ:
            begin
                if (tick)
                begin
                    if (acqCnt_reg == TICK_CW'(ACQ_TICKS - 1))
                    begin
                        state_next = ST_CONV;
                        sarStart   = 1'b1;
                    end
                    else
                    begin
                        acqCnt_next = acqCnt_reg + TICK_CW'(1);
                    end
                end
            end
            ST_CONV:
            begin
                if (sarDone)
                begin
                    result_next    = codeResult(sarResult, ctrl_reg[CB_UNI]);
                    resultUni_next = ctrl_reg[CB_UNI];
                    case (pdSel)
                        PD_FULL:    state_next = ST_SHUTDOWN;
                        PD_STANDBY: state_next = ST_STANDBY;
                        default:    state_next = ST_IDLE;
                    endcase
                end
            end
            default:
            begin
                state_next = ST_POR;
            end
        endcase
    end

    always_comb
    begin
        convDoneB_next = convDoneB_reg;
        if (rdFall || wrRise)
        begin
            convDoneB_next = 1'b1;
        end
        // A completion in the same cycle as a clearing strobe wins
        if (sarDone)
        begin
            convDoneB_next = 1'b0;
        end
        dataOut_next = hbS ? highByte(result_reg, resultUni_reg) : result_reg[BYTE_W-1:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg     <= ST_POR;
            porCnt_reg    <= '0;
            acqCnt_reg    <= '0;
            divCnt_reg    <= '0;
            ctrl_reg      <= CTRL_RESET;
            intClk_reg    <= 1'b0;
            mux_reg       <= '0;
            result_reg    <= '0;
            resultUni_reg <= 1'b1;
            convDoneB_reg <= 1'b1;
            dataOut_reg   <= '0;
            wrPrev_reg    <= 1'b1;
            rdPrev_reg    <= 1'b1;
            clkPrev_reg   <= 1'b1;
        end
        else
        begin
            state_reg     <= state_next;
            porCnt_reg    <= porCnt_next;
            acqCnt_reg    <= acqCnt_next;
            divCnt_reg    <= divCnt_next;
            ctrl_reg      <= ctrl_next;
            intClk_reg    <= intClk_next;
            mux_reg       <= mux_next;
            result_reg    <= result_next;
            resultUni_reg <= resultUni_next;
            convDoneB_reg <= convDoneB_next;
            dataOut_reg   <= dataOut_next;
            wrPrev_reg    <= wrS;
            rdPrev_reg    <= rdS;
            clkPrev_reg   <= clkS;
        end
    end

    assign dataOut       = dataOut_reg;
    assign dataOe        = readActive;
    assign convDoneB     = convDoneB_reg;
    assign {muxPosSel, muxNegSel, muxNegCom} = mux_reg;
    assign trackHold     = (state_reg == ST_ACQ);
    assign analogPowerOn = (state_reg != ST_STANDBY) && (state_reg != ST_SHUTDOWN);
    assign refPowerOn    = (state_reg != ST_SHUTDOWN);
    assign intClkMode    = intClk_reg;
    assign porBusy       = (state_reg == ST_POR);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    chk_reset_defaults:
    assert property (porBusy |-> !intClkMode && convDoneB)
        else $error("Reset state must use external clock with done high");
    chk_por_no_start:
    assert property (porBusy |=> !trackHold)
        else $error("Acquisition started during internal reset");
    chk_single_route:
    assert property (state_reg == ST_IDLE && wrRise && dataS[CB_SGL] && !dataS[CB_ADDR_HI]
                     |=> muxNegCom && muxPosSel == $past(dataS[CB_ADDR_HI:CB_ADDR_LO]))
        else $error("Single-ended input not routed to addressed channel");
    chk_pair_route:
    assert property (state_reg == ST_IDLE && wrRise && !dataS[CB_SGL]
                     |=> !muxNegCom && (muxPosSel ^ muxNegSel) == 3'h1)
        else $error("Pseudo-differential pair not formed");
    chk_low_byte:
    assert property (readActive && !hbS |=> dataOut == $past(result_reg[BYTE_W-1:0]))
        else $error("Low byte does not match result");
    chk_high_fill:
    assert property (readActive && hbS |=> dataOut[BYTE_W-1:2]
                     == {6{!$past(resultUni_reg) && $past(result_reg[RES_BITS-1])}})
        else $error("High byte fill wrong");
    chk_powerdown_port:
    assert property ((state_reg == ST_STANDBY || state_reg == ST_SHUTDOWN) && !wrRise
                     |=> !trackHold && !sarDone && dataOe == (selected && !rdS))
        else $error("Port or converter misbehaves in power-down");
    chk_standby_wake:
    assert property (state_reg == ST_STANDBY && wrRise |=> trackHold && analogPowerOn)
        else $error("Standby did not end on write");
    chk_shutdown_after:
    assert property (state_reg == ST_CONV && !(sarDone && pdSel == PD_FULL) |=> refPowerOn)
        else $error("Shutdown entered during conversion");
    chk_shutdown_wake:
    assert property (state_reg == ST_SHUTDOWN && wrRise |=> ##[0:0] refPowerOn)
        else $error("Shutdown did not end on write");
    chk_result_stable:
    assert property (!sarDone |=> $stable(result_reg))
        else $error("Result changed without a conversion");
    chk_done_low:
    assert property (sarDone |=> !convDoneB)
        else $error("Done output not asserted after conversion");

    cov_full_frame: cover property (trackHold ##[1:300] sarDone);
    cov_standby_entry: cover property (sarDone && pdSel == PD_STANDBY ##1 !analogPowerOn);
    cov_high_read: cover property (readActive && hbS && !resultUni_reg);
endmodule : adcpc_port_control
`default_nettype wire

// File: verification/adcpc_host_model.sv
// Host bus model: writes control bytes, reads results, runs the conversion clock
`default_nettype none
module adcpc_host_model
    import adcpc_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              convDoneB,
    output logic                   chipSelB,
    output logic                   writeB,
    output logic                   readB,
    output logic                   high_byte_select,
    output logic                   convClkPin,
    output logic      [BYTE_W-1:0] dataIn,
    output logic                   grab
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {chipSelB, writeB, readB, high_byte_select, convClkPin, grab} = 6'h38;
        dataIn = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : idle
    task automatic sel(input logic csB);
        chipSelB = csB;
        idle(6);
    endtask : sel
    // Byte held across the strobe rise, then the released lines show its inverse
    task automatic wr(input logic [7:0] b);
        idle(1);
        dataIn = b;
        writeB = 1'b0;
        idle(6);
        writeB = 1'b1;
        idle(6);
        dataIn = ~b;
    endtask : wr
    task automatic rd(input logic hb);
        readB = 1'b0;
        high_byte_select = hb;
        idle(8);
        grab = 1'b1;
        idle(1);
        {grab, readB} = 2'h1;
        idle(2);
    endtask : rd
    // Conversion clock only runs while a frame is awaited
    task automatic waitDone(output int ticks);
        ticks = 0;
        while (convDoneB !== 1'b0 && ticks < 40)
        begin
            convClkPin = 1'b1;
            idle(6);
            convClkPin = 1'b0;
            idle(6);
            ticks++;
        end
    endtask : waitDone
endmodule : adcpc_host_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the converter control block and its four-channel twin
`default_nettype none
module testbench
    import adcpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                core_clk = 1'b0;
    logic                rst_b    = 1'b0;
    logic                chipSelB, writeB, readB, high_byte_select, convClkPin, grab;
    logic [BYTE_W-1:0]   dataIn, dataOut, data4;
    logic                oe4, done4, com4, th4, ap4, rp4, ic4, pb4;
    logic                dataOe, convDoneB, muxNegCom, trackHold, analogPowerOn;
    logic                refPowerOn, intClkMode, porBusy;
    logic [ADDR_W-1:0]   muxPosSel, muxNegSel, pos4, neg4;
    logic [RES_BITS-1:0] dacCode, dac4;
    logic [RES_BITS-1:0] target   = 10'h000;
    logic [31:0]         seed     = 32'h00001f36;
    logic [8:0]          expQ[$];
    logic [8:0]          rdSeen, rdSeen4, exp9;
    int                  mismatches = 0;
    int                  compares   = 0;
    int                  t;
    always #50 core_clk = ~core_clk;
    assign rdSeen = {dataOe, dataOe ? dataOut : 8'h00};
    assign rdSeen4 = {oe4, oe4 ? data4 : 8'h00};
    adcpc_host_model i_host (.core_clk(core_clk), .convDoneB(convDoneB), .chipSelB(chipSelB),
        .writeB(writeB), .readB(readB), .high_byte_select(high_byte_select),
        .convClkPin(convClkPin), .dataIn(dataIn), .grab(grab));
    adcpc_port_control #(.EIGHT_CHANNEL(1'b1)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
        .chipSelB(chipSelB), .writeB(writeB), .readB(readB),
        .high_byte_select(high_byte_select), .convClkPin(convClkPin), .dataIn(dataIn),
        .compHigh(dacCode <= target), .dataOut(dataOut), .dataOe(dataOe),
        .convDoneB(convDoneB), .muxPosSel(muxPosSel), .muxNegSel(muxNegSel),
        .muxNegCom(muxNegCom), .trackHold(trackHold), .dacCode(dacCode),
        .analogPowerOn(analogPowerOn), .refPowerOn(refPowerOn), .intClkMode(intClkMode),
        .porBusy(porBusy));
    adcpc_port_control #(.EIGHT_CHANNEL(1'b0)) i_dut4 (.core_clk(core_clk), .rst_b(rst_b),
        .chipSelB(chipSelB), .writeB(writeB), .readB(readB),
        .high_byte_select(high_byte_select), .convClkPin(convClkPin), .dataIn(dataIn),
        .compHigh(dac4 <= target), .dataOut(data4), .dataOe(oe4), .convDoneB(done4),
        .muxPosSel(pos4), .muxNegSel(neg4), .muxNegCom(com4), .trackHold(th4),
        .dacCode(dac4), .analogPowerOn(ap4), .refPowerOn(rp4), .intClkMode(ic4),
        .porBusy(pb4));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs
    function automatic logic [9:0] res(input logic [9:0] tg, input logic uni);
        return uni ? tg : tg ^ 10'h200;
    endfunction : res
    function automatic logic [7:0] hiByte(input logic [9:0] r, input logic uni);
        return {uni ? 6'h00 : {6{r[9]}}, r[9:8]};
    endfunction : hiByte
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic readBoth(input logic [9:0] r, input logic uni);
        expQ.push_back({1'b1, r[7:0]});
        i_host.rd(1'b0);
        expQ.push_back({1'b1, hiByte(r, uni)});
        i_host.rd(1'b1);
    endtask : readBoth
    task automatic finishFrame;
        i_host.waitDone(t);
        if (convDoneB !== 1'b0)
        begin
            chk("frame end", 16'h0000, 16'h0001);
            conclude();
        end
        chk("twin done", 16'h0000, {15'h0000, done4});
    endtask : finishFrame
    always @(posedge core_clk)
        if (grab === 1'b1)
        begin
            exp9 = expQ.pop_front();
            chk("read", {7'h00, exp9}, {7'h00, rdSeen});
            chk("twin read", {7'h00, exp9}, {7'h00, rdSeen4});
        end
    initial
    begin
        logic [7:0] c;
        logic [9:0] prev, e, s;
        logic       uni, pUni;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1'b1;
        chk("reset", 16'h0003, {12'h000, intClkMode, dataOe, convDoneB, porBusy});
        i_host.sel(1'b0);
        i_host.wr(8'hdd);
        chk("early write", 16'h0001, {11'h000, trackHold, muxPosSel, porBusy});
        i_host.idle(95);
        chk("reset period", 16'h0000, {15'h0000, porBusy});
        i_host.idle(5000);
        target = seed[9:0];
        i_host.wr(8'hdd);
        i_host.sel(1'b1);
        expQ.push_back(9'h000);
        i_host.rd(1'b0);
        i_host.waitDone(t);
        chk("masked ticks", 16'h0028, t[15:0]);
        i_host.sel(1'b0);
        i_host.waitDone(t);
        chk("frame ticks", 16'h0010, t[15:0]);
        chk("ext mode", 16'h0000, {15'h0000, intClkMode});
        readBoth(target, 1'b1);
        prev = target;
        pUni = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            uni = seed[10];
            target = seed[9:0];
            c = {2'h2, 1'b0, i[3], uni, i[2:0]};
            i_host.wr(c);
            s = {muxNegCom, muxPosSel, c[4] ? 3'h0 : muxNegSel, pos4};
            e = {c[4], c[2:0], c[4] ? 3'h0 : c[2:0] ^ 3'h1, 1'b0, c[1:0]};
            chk("mux", {6'h00, e}, {6'h00, s});
            chk("twin", {7'h00, c[4], c[4] ? 3'h0 : {1'b0, c[1], ~c[0]}, 5'h1e},
                {7'h00, com4, c[4] ? 3'h0 : neg4, th4, ap4, rp4, ic4, pb4});
            readBoth(prev, pUni);
            finishFrame();
            chk("int mode", 16'h0001, {15'h0000, intClkMode});
            prev = res(target, uni);
            pUni = uni;
        end
        readBoth(prev, pUni);
        target = 10'h1c5;
        i_host.wr(8'h5a);
        finishFrame();
        chk("standby", 16'h0003, {13'h0000, analogPowerOn, refPowerOn, intClkMode});
        readBoth(10'h1c5, 1'b1);
        i_host.wr(8'h9a);
        chk("standby wake", 16'h0001, {15'h0000, analogPowerOn});
        finishFrame();
        i_host.wr(8'h1a);
        chk("busy shutdown", 16'h0001, {15'h0000, analogPowerOn});
        finishFrame();
        chk("shutdown", 16'h0000, {14'h0000, analogPowerOn, refPowerOn});
        readBoth(10'h1c5, 1'b1);
        i_host.wr(8'hd2);
        chk("shutdown wake", 16'h0003, {14'h0000, analogPowerOn, refPowerOn});
        i_host.idle(500);
        finishFrame();
        readBoth(res(10'h1c5, 1'b0), 1'b0);
        conclude();
    end
endmodule : testbench
`default_nettype wire
